/* include/sso_map.svh */
// Address map, field layout, reset values and timing counts of the standby block.
// What this block does
// (RQ1) Halt instruction gates the CPU clock while all program state stays intact.
// (RQ2) During HALT every oscillator that was running keeps running.
// (RQ3) Stop instruction enters STOP and halts the X1 oscillator.
// (RQ4) An interrupt request releases STOP.
// (RQ5) After STOP release a wait for X1 stabilization precedes normal operation.
// (RQ6) Registers, flags and data memory are held in both standby modes.
// (RQ7) Port output latches and output buffers are held in both standby modes.
// (RQ8) Software enters STOP only from X1 or internal clock; HALT from any.
// (RQ9) STOP from internal clock stops X1 but leaves the internal oscillator running.
// (RQ10) STOP never stops a running internal oscillator; CPU stalls 17 periods after release.
// (RQ11) Software stops peripherals and A/D conversion before entering standby.
// (RQ12) After release the CPU resumes on the clock selected at standby entry.
// (RQ13) Software internal oscillator stop works only when the build option allows it.
// (RQ14) Status register is readable by bit or byte and not writable.
// (RQ15) Status clears on reset, stop instruction, X1 halt or main clock halt.
// (RQ16) Status bits 4..0 report 2^11,2^13,2^14,2^15,2^16 X1 periods; 7..5 zero.
// (RQ17) Bits set in order from the shortest threshold and stay set until cleared.
// (RQ18) Counter runs only up to the selected stabilization duration.
// (RQ19) Software selects a duration at least as long as the status it polls.
// (RQ20) Wait counts from oscillation start, excluding startup, for any release.
// (RQ21) Select field is 3 bits; codes 1..5 choose thresholds, others prohibited.
// (RQ22) Select register resets to 05H and sits at FFA4H.
// (RQ23) Selected wait stalls the CPU only when X1 is the CPU clock.
// (RQ24) HALT ends on interrupt or reset with no stabilization wait.
`ifndef SSO_MAP_SVH
`define SSO_MAP_SVH
`define SSO_ADDR_STATUS 16'hffa3
`define SSO_ADDR_SELECT 16'hffa4
`define SSO_SELECT_RESET 3'h5
`define SSO_SELECT_W 3
`define SSO_FLAG_N 5
`define SSO_STATUS_PAD 3'h0
`define SSO_BYTE_ZERO 8'h00
`define SSO_CNT_W 17
`define SSO_CNT_ZERO 17'h0_0000
`define SSO_CNT_ONE 17'h0_0001
`define SSO_THR_STEP1 17'h0_0800
`define SSO_THR_STEP2 17'h0_2000
`define SSO_THR_STEP3 17'h0_4000
`define SSO_THR_STEP4 17'h0_8000
`define SSO_THR_STEP5 17'h1_0000
`define SSO_SEL_STEP1 3'h1
`define SSO_SEL_STEP2 3'h2
`define SSO_SEL_STEP3 3'h3
`define SSO_SEL_STEP4 3'h4
`define SSO_SEL_STEP5 3'h5
`define SSO_IOSC_STALL_W 5
`define SSO_IOSC_STALL 5'h11
`define SSO_IOSC_STALL_ZERO 5'h00
`define SSO_IOSC_STALL_ONE 5'h01
`endif

/* include/sso_pkg.sv */
// Types shared by the standby and stabilization block.
package sso_pkg;
  typedef enum logic [4:0] {
    SSO_RUN       = 5'h01,
    SSO_HALT      = 5'h02,
    SSO_STOP      = 5'h04,
    SSO_WAIT_X1   = 5'h08,
    SSO_WAIT_IOSC = 5'h10
  } sso_state_t;
  typedef enum logic [1:0] {
    SSO_SRC_X1   = 2'h0,
    SSO_SRC_IOSC = 2'h1,
    SSO_SRC_SUB  = 2'h2
  } sso_clk_src_t;
endpackage

/* logic/sso_standby.sv */
// Standby controller with X1 oscillation stabilization counter and status register.
`timescale 1ns/1ps
`include "sso_map.svh"
module sso_standby #(
  parameter int CNT_W   = `SSO_CNT_W,
  parameter int FLAG_N  = `SSO_FLAG_N
) (
  input  wire logic        I_CLK,
  input  wire logic        I_NRST,
  input  wire logic        I_CE,
  input  wire logic        I_HALT_EXEC,
  input  wire logic        I_STOP_EXEC,
  input  wire logic        I_INT_REQ,
  input  wire logic [1:0]  I_CPU_CLK_SRC,
  input  wire logic        I_X1_OSC_HALT,
  input  wire logic        I_MAIN_CLK_HALT,
  input  wire logic        I_IOSC_HALT_REQ,
  input  wire logic        I_IOSC_SW_STOP_OPT,
  input  wire logic        I_X1_TICK,
  input  wire logic        I_X1_OSC_ACTIVE,
  input  wire logic        I_IOSC_TICK,
  input  wire logic [15:0] I_ADDR,
  input  wire logic [7:0]  I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  output logic       [7:0] O_RDATA,
  output logic             O_CPU_CLK_EN,
  output logic       [1:0] O_CPU_CLK_SEL,
  output logic             O_IN_HALT,
  output logic             O_IN_STOP,
  output logic             O_X1_OSC_EN,
  output logic             O_IOSC_EN,
  output logic             O_SUB_OSC_EN
);

  // The threshold table and status layout are fixed, so other sizes are refused.
  if (CNT_W != `SSO_CNT_W || FLAG_N != `SSO_FLAG_N) begin : g_bad_size
    $error("Counter width and flag count are fixed by the threshold table.");
  end

  sso_pkg::sso_state_t   state_q;
  sso_pkg::sso_state_t   state_d;
  sso_pkg::sso_clk_src_t src_q;
  logic [`SSO_SELECT_W-1:0]     select_q;
  logic [CNT_W-1:0]             cnt_q;
  logic                         cnt_run_q;
  logic [FLAG_N-1:0]            flag_q;
  logic [`SSO_IOSC_STALL_W-1:0] stall_q;
  logic [7:0]                   rdata_q;
  logic                         x1_en_q;
  logic                         iosc_en_q;
  logic                         sub_en_q;
  logic [CNT_W-1:0]             sel_limit;
  logic                         limit_hit;
  logic                         status_clr;
  logic                         stop_release;
  logic [CNT_W-1:0]             thr [FLAG_N];

  assign thr[0] = `SSO_THR_STEP1;
  assign thr[1] = `SSO_THR_STEP2;
  assign thr[2] = `SSO_THR_STEP3;
  assign thr[3] = `SSO_THR_STEP4;
  assign thr[4] = `SSO_THR_STEP5;

  // Duration chosen by the select register; counting and the X1 wait both end here.
  always_comb begin
    unique case (select_q)
      `SSO_SEL_STEP1: sel_limit = `SSO_THR_STEP1; // see (RQ21)
      `SSO_SEL_STEP2: sel_limit = `SSO_THR_STEP2;
      `SSO_SEL_STEP3: sel_limit = `SSO_THR_STEP3;
      `SSO_SEL_STEP4: sel_limit = `SSO_THR_STEP4;
      default:        sel_limit = `SSO_THR_STEP5;
    endcase
  end

  assign limit_hit = (cnt_q >= sel_limit);
  // Either oscillator stop control or a fresh STOP wipes the elapsed-time record.
  assign status_clr = I_X1_OSC_HALT | I_MAIN_CLK_HALT |
                      (state_q == sso_pkg::SSO_RUN && I_STOP_EXEC); // see (RQ15)
  assign stop_release = (state_q == sso_pkg::SSO_STOP) && I_INT_REQ;

  // Mode sequencing.
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      sso_pkg::SSO_RUN: begin
        // STOP from the subsystem clock is not a legal request and is ignored.
        if (I_STOP_EXEC && I_CPU_CLK_SRC != sso_pkg::SSO_SRC_SUB) begin // see (RQ8)
          state_d = sso_pkg::SSO_STOP; // see (RQ3)
        end else if (I_HALT_EXEC) begin
          state_d = sso_pkg::SSO_HALT; // see (RQ1)
        end
      end
      sso_pkg::SSO_HALT: begin
        if (I_INT_REQ) begin
          state_d = sso_pkg::SSO_RUN; // see (RQ24)
        end
      end
      sso_pkg::SSO_STOP: begin
        if (I_INT_REQ) begin // see (RQ4)
          if (src_q == sso_pkg::SSO_SRC_X1) begin
            state_d = sso_pkg::SSO_WAIT_X1; // see (RQ5) see (RQ23)
          end else begin
            state_d = sso_pkg::SSO_WAIT_IOSC; // see (RQ10)
          end
        end
      end
      sso_pkg::SSO_WAIT_X1: begin
        if (limit_hit) begin
          state_d = sso_pkg::SSO_RUN;
        end
      end
      sso_pkg::SSO_WAIT_IOSC: begin
        if (stall_q == `SSO_IOSC_STALL) begin
          state_d = sso_pkg::SSO_RUN; // see (RQ10)
        end
      end
      default: state_d = sso_pkg::SSO_RUN;
    endcase
  end

  // The CPU clock gate is the only thing frozen; registers, memory and port
  // latches simply see no clock, so their contents and drive stay as they were.
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      state_q <= sso_pkg::SSO_RUN;
    end else if (I_CE) begin
      state_q <= state_d; // see (RQ6) see (RQ7)
    end
  end

  // Clock source captured at standby entry and handed back on release.
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      src_q <= sso_pkg::SSO_SRC_IOSC;
    end else if (I_CE) begin
      if (state_q == sso_pkg::SSO_RUN) begin
        src_q <= sso_pkg::sso_clk_src_t'(I_CPU_CLK_SRC); // see (RQ12)
      end
    end
  end

  // Stall timer in internal oscillator periods after a STOP release.
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      stall_q <= `SSO_IOSC_STALL_ZERO;
    end else if (I_CE) begin
      if (state_q != sso_pkg::SSO_WAIT_IOSC) begin
        stall_q <= `SSO_IOSC_STALL_ZERO;
      end else if (I_IOSC_TICK && stall_q != `SSO_IOSC_STALL) begin
        stall_q <= stall_q + `SSO_IOSC_STALL_ONE; // see (RQ10)
      end
    end
  end

  // Select register; a prohibited code is refused and the old value kept.
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      select_q <= `SSO_SELECT_RESET; // see (RQ22)
    end else if (I_CE) begin
      if (I_WR && I_ADDR == `SSO_ADDR_SELECT &&
          I_WDATA[`SSO_SELECT_W-1:0] >= `SSO_SEL_STEP1 &&
          I_WDATA[`SSO_SELECT_W-1:0] <= `SSO_SEL_STEP5) begin
        select_q <= I_WDATA[`SSO_SELECT_W-1:0]; // see (RQ21)
      end
    end
  end

  // Counter runs after reset and after STOP release, and only up to the chosen
  // duration, so longer thresholds are never reported for a short selection.
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      cnt_run_q <= 1'b1;
    end else if (I_CE) begin
      if (stop_release) begin
        cnt_run_q <= 1'b1;
      end else if (limit_hit || status_clr) begin
        cnt_run_q <= 1'b0; // see (RQ18)
      end
    end
  end

  // Ticks only count once the oscillator reports steady oscillation, so the
  // startup interval is excluded whatever released STOP.
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      cnt_q <= `SSO_CNT_ZERO;
    end else if (I_CE) begin
      if (status_clr) begin
        cnt_q <= `SSO_CNT_ZERO;
      end else if (cnt_run_q && !limit_hit && I_X1_TICK && I_X1_OSC_ACTIVE &&
                   state_q != sso_pkg::SSO_STOP) begin
        cnt_q <= cnt_q + `SSO_CNT_ONE; // see (RQ20)
      end
    end
  end

  // Thresholds rise with the index, so flags fill from the shortest one.
  for (genvar k = 0; k < FLAG_N; k++) begin : g_flag
    always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
        flag_q[k] <= 1'b0;
      end else if (I_CE) begin
        if (status_clr) begin
          flag_q[k] <= 1'b0; // see (RQ15)
        end else if (cnt_q >= thr[k]) begin
          flag_q[k] <= 1'b1; // see (RQ17)
        end
      end
    end
  end

  // Byte read serves bit reads too; the status address has no write path.
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      rdata_q <= `SSO_BYTE_ZERO;
    end else if (I_CE) begin
      if (I_RD && I_ADDR == `SSO_ADDR_STATUS) begin
        rdata_q <= {`SSO_STATUS_PAD, flag_q[0], flag_q[1], flag_q[2],
                    flag_q[3], flag_q[4]}; // see (RQ14) see (RQ16)
      end else if (I_RD && I_ADDR == `SSO_ADDR_SELECT) begin
        rdata_q <= {{(8 - `SSO_SELECT_W){1'b0}}, select_q};
      end else if (I_RD) begin
        rdata_q <= `SSO_BYTE_ZERO;
      end
    end
  end

  // X1 stops in STOP whatever the CPU clock; HALT leaves it alone.
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      x1_en_q <= 1'b0;
    end else if (I_CE) begin
      x1_en_q <= (state_d != sso_pkg::SSO_STOP) && !I_X1_OSC_HALT; // see (RQ2) see (RQ9)
    end
  end

  // The internal oscillator ignores STOP and obeys software only when the
  // build option permits it.
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      iosc_en_q <= 1'b1;
    end else if (I_CE) begin
      iosc_en_q <= !(I_IOSC_HALT_REQ && I_IOSC_SW_STOP_OPT); // see (RQ13) see (RQ10)
    end
  end

  // The subsystem oscillator is never touched by either standby mode.
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      sub_en_q <= 1'b0;
    end else if (I_CE) begin
      sub_en_q <= 1'b1; // see (RQ2)
    end
  end

  assign O_RDATA       = rdata_q;
  assign O_CPU_CLK_EN  = state_q[0];
  assign O_CPU_CLK_SEL = src_q;
  assign O_IN_HALT     = state_q[1];
  assign O_IN_STOP     = state_q[2];
  assign O_X1_OSC_EN   = x1_en_q;
  assign O_IOSC_EN     = iosc_en_q;
  assign O_SUB_OSC_EN  = sub_en_q;

endmodule // sso_standby

/* testbench/sso_standby_properties.sv */
// Port-level assertions for the standby controller.
`timescale 1ns/1ps
module sso_standby_properties (
  input wire logic        I_CLK,
  input wire logic        I_NRST,
  input wire logic        I_CE,
  input wire logic        I_HALT_EXEC,
  input wire logic        I_STOP_EXEC,
  input wire logic        I_INT_REQ,
  input wire logic [1:0]  I_CPU_CLK_SRC,
  input wire logic        I_IOSC_SW_STOP_OPT,
  input wire logic [15:0] I_ADDR,
  input wire logic        I_RD,
  input wire logic [7:0]  O_RDATA,
  input wire logic        O_CPU_CLK_EN,
  input wire logic [1:0]  O_CPU_CLK_SEL,
  input wire logic        O_IN_HALT,
  input wire logic        O_IN_STOP,
  input wire logic        O_X1_OSC_EN,
  input wire logic        O_IOSC_EN
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);
  logic run;
  logic rd_st;
  assign run = O_CPU_CLK_EN && I_CE;
  assign rd_st = I_RD && I_CE && I_ADDR == 16'hffa3;
  // Both release waits outlast eight cycles, so a release that skips its wait shows here.
  sequence stall_s;
    !O_CPU_CLK_EN [*8];
  endsequence
  sequence released_s(logic [1:0] s);
    $fell(O_IN_STOP) && O_CPU_CLK_SEL == s;
  endsequence
  halt_entry_a: assert property (
    run && I_HALT_EXEC && !I_STOP_EXEC |=> O_IN_HALT && !O_CPU_CLK_EN) else $error("halt entry");
  stop_entry_a: assert property (
    run && I_STOP_EXEC && I_CPU_CLK_SRC != 2'h2 |=> O_IN_STOP && !O_X1_OSC_EN && !O_CPU_CLK_EN)
    else $error("stop entry");
  stop_refuse_a: assert property (
    run && I_STOP_EXEC && !I_HALT_EXEC && I_CPU_CLK_SRC == 2'h2 |=> O_CPU_CLK_EN && !O_IN_STOP)
    else $error("stop from subsystem clock taken");
  halt_wake_a: assert property (
    O_IN_HALT && I_INT_REQ && I_CE |-> ##[1:2] O_CPU_CLK_EN) else $error("halt release late");
  stop_wake_a: assert property (
    O_IN_STOP && I_INT_REQ && I_CE |=> !O_IN_STOP) else $error("stop not released");
  x1_wait_a: assert property (
    released_s(2'h0) |-> stall_s) else $error("no stabilization wait");
  iosc_wait_a: assert property (
    released_s(2'h1) |-> O_IOSC_EN throughout stall_s) else $error("internal clock stall");
  sel_hold_a: assert property (
    !O_CPU_CLK_EN |=> $stable(O_CPU_CLK_SEL)) else $error("clock source changed in standby");
  status_read_a: assert property (
    $past(rd_st) |-> O_RDATA[7:5] == 3'h0 && (O_RDATA[3:0] & ~O_RDATA[4:1]) == 4'h0)
    else $error("status flags out of order");
  iosc_opt_a: assert property (
    !I_IOSC_SW_STOP_OPT |=> O_IOSC_EN) else $error("internal oscillator stopped");
endmodule // sso_standby_properties
bind sso_standby sso_standby_properties chk (
  .I_CLK(I_CLK), .I_NRST(I_NRST), .I_CE(I_CE), .I_HALT_EXEC(I_HALT_EXEC),
  .I_STOP_EXEC(I_STOP_EXEC), .I_INT_REQ(I_INT_REQ), .I_CPU_CLK_SRC(I_CPU_CLK_SRC),
  .I_IOSC_SW_STOP_OPT(I_IOSC_SW_STOP_OPT), .I_ADDR(I_ADDR), .I_RD(I_RD), .O_RDATA(O_RDATA),
  .O_CPU_CLK_EN(O_CPU_CLK_EN), .O_CPU_CLK_SEL(O_CPU_CLK_SEL), .O_IN_HALT(O_IN_HALT),
  .O_IN_STOP(O_IN_STOP), .O_X1_OSC_EN(O_X1_OSC_EN), .O_IOSC_EN(O_IOSC_EN)
);

/* testbench/sso_osc_model.sv */
// Clock source model: X1 oscillator with a startup interval and internal oscillator ticks.
`timescale 1ns/1ps
module sso_osc_model #(
  parameter int STARTUP = 6
) (
  input  wire logic i_clk,
  input  wire logic i_nrst,
  input  wire logic i_x1_en,
  input  wire logic i_iosc_en,
  output logic      o_x1_tick,
  output logic      o_x1_active,
  output logic      o_iosc_tick
);
  logic [3:0] start_q;
  logic       half_q;
  // No X1 ticks during startup, so a counter that starts early gains nothing.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst || !i_x1_en) begin
      start_q <= 4'h0;
    end else if (start_q != STARTUP[3:0]) begin
      start_q <= start_q + 4'h1;
    end
  end
  assign o_x1_active = start_q == STARTUP[3:0];
  assign o_x1_tick = o_x1_active;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      half_q <= 1'b0;
    end else begin
      half_q <= i_iosc_en && !half_q;
    end
  end
  assign o_iosc_tick = half_q;
endmodule // sso_osc_model

/* testbench/standby_osc_stabilization_test.sv */
// Self-checking bench for the standby and stabilization block.
`timescale 1ns/1ps
`include "sso_map.svh"
module standby_osc_stabilization_test;
  localparam int SU = 6;
  logic        clk, nrst, halt_x, stop_x, int_req, x1_halt, mc_halt, io_req, io_opt, wr, rd;
  logic [1:0]  src, clk_sel;
  logic [15:0] addr;
  logic [7:0]  wdata, rdata, d;
  logic        clk_en, in_halt, in_stop, x1_en, io_en, sub_en, x1_tick, x1_act, io_tick;
  int          err_count, checks, seed, n;
  sso_standby uut (.I_CLK(clk), .I_NRST(nrst), .I_CE(1'b1), .I_HALT_EXEC(halt_x),
    .I_STOP_EXEC(stop_x), .I_INT_REQ(int_req), .I_CPU_CLK_SRC(src), .I_X1_OSC_HALT(x1_halt),
    .I_MAIN_CLK_HALT(mc_halt), .I_IOSC_HALT_REQ(io_req), .I_IOSC_SW_STOP_OPT(io_opt),
    .I_X1_TICK(x1_tick), .I_X1_OSC_ACTIVE(x1_act), .I_IOSC_TICK(io_tick), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .O_CPU_CLK_EN(clk_en),
    .O_CPU_CLK_SEL(clk_sel), .O_IN_HALT(in_halt), .O_IN_STOP(in_stop), .O_X1_OSC_EN(x1_en),
    .O_IOSC_EN(io_en), .O_SUB_OSC_EN(sub_en));
  sso_osc_model #(.STARTUP(SU)) osc (.i_clk(clk), .i_nrst(nrst), .i_x1_en(x1_en),
    .i_iosc_en(io_en), .o_x1_tick(x1_tick), .o_x1_active(x1_act), .o_iosc_tick(io_tick));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  function automatic int thr(int c);
    return (c == 1) ? 2048 : (1 << (c + 11));
  endfunction
  function automatic logic [7:0] flags(int c);
    return 8'h1f & ~(8'h1f >> c);
  endfunction
  task automatic final_report();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] v);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
  endtask
  // The bench models no peripherals, so they are idle at every standby entry.
  task automatic enter(input logic [1:0] s, input logic stp);
    @(posedge clk);
    src <= s;
    stop_x <= stp;
    halt_x <= !stp;
    @(posedge clk);
    stop_x <= 1'b0;
    halt_x <= 1'b0;
    #1;
  endtask
  task automatic wake(input int lim);
    @(posedge clk);
    int_req <= 1'b1;
    @(posedge clk);
    int_req <= 1'b0;
    n = 0;
    #1;
    while (clk_en !== 1'b1) begin
      n++;
      if (n > lim) begin
        err_count++;
        final_report();
      end
      @(posedge clk);
      #1;
    end
  endtask
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask
  initial begin
    seed = 80574;
    {halt_x, stop_x, int_req, x1_halt, mc_halt, io_req, io_opt, wr, rd} = 9'h000;
    {src, addr, wdata, nrst, err_count, checks} = '0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    bus(1'b0, `SSO_ADDR_STATUS, 8'h00);
    chk(rdata, 8'h00);
    bus(1'b0, `SSO_ADDR_SELECT, 8'h00);
    chk(rdata, 8'h05);
    d = $random(seed);
    bus(1'b1, `SSO_ADDR_STATUS, d);
    bus(1'b0, `SSO_ADDR_STATUS, 8'h00);
    chk(rdata, 8'h00);
    bus(1'b0, 16'hff00, 8'h00);
    chk(rdata, 8'h00);
    for (int s = 0; s < 3; s++) begin
      enter(s[1:0], 1'b0);
      chk({3'h0, in_halt, clk_en, x1_en, io_en, sub_en}, 8'h17);
      wake(3);
      chk({4'h0, in_halt, clk_en, clk_sel}, 8'h04 | 8'(s));
    end
    // Stop from the subsystem clock is the one refused standby entry the bench provokes.
    enter(2'h2, 1'b1);
    chk({6'h0, in_stop, clk_en}, 8'h01);
    @(posedge clk);
    io_req <= 1'b1;
    settle();
    chk({7'h0, io_en}, 8'h01);
    io_opt <= 1'b1;
    settle();
    chk({7'h0, io_en}, 8'h00);
    io_req <= 1'b0;
    io_opt <= 1'b0;
    settle();
    enter(2'h1, 1'b1);
    chk({5'h0, in_stop, x1_en, io_en}, 8'h05);
    wake(60);
    chk(8'(n >= 32 && n <= 40), 8'h01);
    // Select is still 5, which covers the shortest status step that is polled here.
    repeat (2100) @(posedge clk);
    bus(1'b0, `SSO_ADDR_STATUS, 8'h00);
    chk(rdata, 8'h10);
    for (int c = 1; c < 5; c++) begin
      d = $random(seed);
      d[2:0] = (d[2:0] inside {[1:5]}) ? 3'h0 : d[2:0];
      bus(1'b1, `SSO_ADDR_SELECT, d);
      bus(1'b0, `SSO_ADDR_SELECT, 8'h00);
      chk(rdata, 8'((c == 1) ? 5 : c - 1));
      bus(1'b1, `SSO_ADDR_SELECT, 8'(c));
      enter(2'h0, 1'b1);
      chk({5'h0, in_stop, x1_en, clk_en}, 8'h04);
      bus(1'b0, `SSO_ADDR_STATUS, 8'h00);
      chk(rdata, 8'h00);
      wake(thr(c) + SU + 8);
      chk(8'(n >= thr(c) + SU && n <= thr(c) + SU + 4), 8'h01);
      repeat ($random(seed) & 7) @(posedge clk);
      bus(1'b0, `SSO_ADDR_STATUS, 8'h00);
      chk(rdata, flags(c));
      @(posedge clk);
      x1_halt <= c[0];
      mc_halt <= !c[0];
      @(posedge clk);
      {x1_halt, mc_halt} <= 2'h0;
      bus(1'b0, `SSO_ADDR_STATUS, 8'h00);
      chk(rdata, 8'h00);
    end
    final_report();
  end
endmodule // standby_osc_stabilization_test
